// ---- verilog/sram_host_regs.vh ----
// timing constants and field definitions for the asynchronous sram host controller
`ifndef SRAM_HOST_REGS_VH
`define SRAM_HOST_REGS_VH

// =====================================================================
// clock
`define CLK_PERIOD_NS       20

// =====================================================================
// device timing in ns, as printed
`define T_READ_CYCLE_NS     45
`define T_ADDR_ACCESS_NS    45
`define T_OUT_ENABLE_NS     25
`define T_ADDR_WRITE_NS     40
`define T_CHIP_WRITE_NS     40
`define T_WRITE_PULSE_NS    35
`define T_LANE_WRITE_NS     35
`define T_DATA_SETUP_NS     20
`define T_TURNOFF_NS        15
`define T_CHIP_HIGHZ_NS     15
`define T_RETENTION_NS      0

// =====================================================================
// cycle counts: minimum times round up, never below one cycle
`define CYC_MIN(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CYC_READ     `CYC_MIN(`T_READ_CYCLE_NS)
`define CYC_WRITE    `CYC_MIN(`T_ADDR_WRITE_NS)
`define CYC_SETUP    `CYC_MIN(`T_DATA_SETUP_NS)
`define CYC_TURNOFF  `CYC_MIN(`T_TURNOFF_NS)
`define CYC_HIGHZ    `CYC_MIN(`T_CHIP_HIGHZ_NS)

// =====================================================================
// widths
`define ADDR_W       18
`define DATA_W       16
`define LANE_LOW     7:0
`define LANE_HIGH    15:8
`define CNT_W        4

`endif

// ---- verilog/sram_host.v ----
// host controller driving an asynchronous 256k x 16 sram through its pins
`timescale 1ns/1ps
`include "sram_host_regs.vh"

module sram_host #(
    parameter ADDR_W = `ADDR_W,
    parameter DATA_W = `DATA_W
) (
    // clock and reset
    input  wire              core_clk,
    input  wire              rst,
    // user request side
    input  wire              req_valid,
    input  wire              req_write,
    input  wire [ADDR_W-1:0] req_addr,
    input  wire [DATA_W-1:0] req_wdata,
    input  wire [1:0]        req_lanes,
    input  wire              retain_req,
    output reg               req_ready,
    output reg               rsp_valid,
    output reg  [DATA_W-1:0] rsp_rdata,
    output reg               retain_ok,
    // memory pins
    output reg  [ADDR_W-1:0] word_address,
    output reg               chip_select_n,
    output reg               write_strobe_n,
    output reg               output_drive_n,
    output reg               low_lane_select_n,
    output reg               high_lane_select_n,
    input  wire [DATA_W-1:0] data_bus_in,
    output reg  [DATA_W-1:0] data_bus_out,
    output reg               data_bus_oe
);

// =====================================================================
// states
localparam [2:0] ST_IDLE   = 3'h0;
localparam [2:0] ST_RSETUP = 3'h1;
localparam [2:0] ST_READ   = 3'h2;
localparam [2:0] ST_WSETUP = 3'h3;
localparam [2:0] ST_WRITE  = 3'h4;
localparam [2:0] ST_FLOAT  = 3'h5;
localparam [2:0] ST_RETAIN = 3'h6;

localparam integer N_READ_I    = `CYC_READ;
localparam integer N_WRITE_I   = `CYC_WRITE;
localparam integer N_TURNOFF_I = `CYC_TURNOFF;
localparam integer N_HIGHZ_I   = `CYC_HIGHZ;
localparam integer N_SETUP_I   = `CYC_SETUP;

// counts cut to the counter width on purpose; all fit well below its top
localparam [`CNT_W-1:0] N_READ    = N_READ_I[`CNT_W-1:0];
localparam [`CNT_W-1:0] N_WRITE   = N_WRITE_I[`CNT_W-1:0];
localparam [`CNT_W-1:0] N_TURNOFF = N_TURNOFF_I[`CNT_W-1:0];
localparam [`CNT_W-1:0] N_HIGHZ   = N_HIGHZ_I[`CNT_W-1:0];
localparam [`CNT_W-1:0] N_SETUP   = N_SETUP_I[`CNT_W-1:0];

reg [2:0]        state_q;
reg [`CNT_W-1:0] cnt_q;

// an empty lane mask would be a standby access; treat it as both lanes
function [1:0] lanes_of;
    input [1:0] l;
    begin
        lanes_of = (l == 2'h0) ? 2'h3 : l;
    end
endfunction

// =====================================================================
// lane mask is captured with the request; an empty mask is widened at use
reg  [1:0] req_lanes_q;
wire [1:0] lane_sel = lanes_of(req_lanes_q);

always @(posedge core_clk) begin
    if (rst)
        req_lanes_q <= 2'h0;
    else if (state_q == ST_IDLE && req_valid && req_ready)
        req_lanes_q <= req_lanes;
end

// =====================================================================
// pin sequencer
always @(posedge core_clk) begin
    if (rst) begin
        state_q            <= ST_IDLE;
        cnt_q              <= {`CNT_W{1'b0}};
        req_ready          <= 1'b0;
        rsp_valid          <= 1'b0;
        rsp_rdata          <= {DATA_W{1'b0}};
        retain_ok          <= 1'b0;
        word_address       <= {ADDR_W{1'b0}};
        chip_select_n      <= 1'b1;
        write_strobe_n     <= 1'b1;
        output_drive_n     <= 1'b1;
        low_lane_select_n  <= 1'b1;
        high_lane_select_n <= 1'b1;
        data_bus_out       <= {DATA_W{1'b0}};
        data_bus_oe        <= 1'b0;
    end else begin
        rsp_valid <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                chip_select_n      <= 1'b1;
                low_lane_select_n  <= 1'b1;
                high_lane_select_n <= 1'b1;
                write_strobe_n     <= 1'b1;
                output_drive_n     <= 1'b1;
                data_bus_oe        <= 1'b0;
                retain_ok          <= 1'b0;
                if (retain_req) begin
                    req_ready <= 1'b0;
                    state_q   <= ST_RETAIN;
                end else if (req_valid && req_ready) begin
                    req_ready    <= 1'b0;
                    // address set one cycle ahead of any select falling
                    word_address <= req_addr;
                    data_bus_out <= req_wdata;
                    low_lane_select_n  <= 1'b1;
                    high_lane_select_n <= 1'b1;
                    state_q <= req_write ? ST_WSETUP : ST_RSETUP;
                    cnt_q   <= {`CNT_W{1'b0}};
                end else begin
                    req_ready <= 1'b1;
                end
            end
            ST_RSETUP: begin
                // strobe stays high and host bus stays off during reads
                write_strobe_n     <= 1'b1;
                data_bus_oe        <= 1'b0;
                chip_select_n      <= 1'b0;
                output_drive_n     <= 1'b0;
                low_lane_select_n  <= ~lane_sel[0];
                high_lane_select_n <= ~lane_sel[1];
                cnt_q   <= {`CNT_W{1'b0}};
                state_q <= ST_READ;
            end
            ST_READ: begin
                cnt_q <= cnt_q + 1'b1;
                // wait the full access time; data then settled
                if (cnt_q == N_READ - 1'b1) begin
                    rsp_rdata[`LANE_LOW]  <= low_lane_select_n  ? 8'h00 : data_bus_in[`LANE_LOW];
                    rsp_rdata[`LANE_HIGH] <= high_lane_select_n ? 8'h00 : data_bus_in[`LANE_HIGH];
                    rsp_valid          <= 1'b1;
                    chip_select_n      <= 1'b1;
                    output_drive_n     <= 1'b1;
                    low_lane_select_n  <= 1'b1;
                    high_lane_select_n <= 1'b1;
                    cnt_q   <= {`CNT_W{1'b0}};
                    state_q <= ST_FLOAT;
                end
            end
            ST_WSETUP: begin
                // strobe falls with the selects, so device outputs never turn on
                output_drive_n     <= 1'b1;
                chip_select_n      <= 1'b0;
                write_strobe_n     <= 1'b0;
                low_lane_select_n  <= ~lane_sel[0];
                high_lane_select_n <= ~lane_sel[1];
                cnt_q   <= {`CNT_W{1'b0}};
                state_q <= ST_WRITE;
            end
            ST_WRITE: begin
                cnt_q <= cnt_q + 1'b1;
                // drive only after the device's turnoff window has passed
                if (cnt_q == N_TURNOFF - 1'b1)
                    data_bus_oe <= 1'b1;
                // strobe ends after address, chip, lane and data windows
                if (cnt_q >= N_WRITE && cnt_q >= N_TURNOFF + N_SETUP) begin
                    write_strobe_n     <= 1'b1;
                    chip_select_n      <= 1'b1;
                    low_lane_select_n  <= 1'b1;
                    high_lane_select_n <= 1'b1;
                    cnt_q   <= {`CNT_W{1'b0}};
                    state_q <= ST_FLOAT;
                end
            end
            ST_FLOAT: begin
                // data held one edge past write end; then released
                data_bus_oe <= 1'b0;
                cnt_q <= cnt_q + 1'b1;
                if (cnt_q == N_HIGHZ - 1'b1) begin
                    cnt_q   <= {`CNT_W{1'b0}};
                    state_q <= ST_IDLE;
                end
            end
            ST_RETAIN: begin
                chip_select_n <= 1'b1;
                data_bus_oe   <= 1'b0;
                retain_ok     <= 1'b1;
                if (!retain_req) begin
                    retain_ok <= 1'b0;
                    cnt_q     <= {`CNT_W{1'b0}};
                    state_q   <= ST_FLOAT;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
    end
end

endmodule

// ---- tb/sram_host_monitor.sv ----
// checker of the host's memory pin sequencing
`timescale 1ns/1ps
module sram_host_monitor (
    // clock, reset and requests
    input wire        core_clk,
    input wire        rst,
    input wire        req_valid,
    input wire        req_write,
    input wire        req_ready,
    input wire        rsp_valid,
    input wire        retain_ok,
    // memory pins
    input wire [17:0] word_address,
    input wire        chip_select_n,
    input wire        write_strobe_n,
    input wire        output_drive_n,
    input wire        low_lane_select_n,
    input wire        high_lane_select_n,
    input wire        data_bus_oe
);
    // ==========
    // pin rules
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire lanes_on = !low_lane_select_n || !high_lane_select_n;
    read_strobe_a: assert property (!chip_select_n && !output_drive_n |-> write_strobe_n)
        else $error("strobe low in read");
    addr_stable_a: assert property (!chip_select_n |-> $stable(word_address))
        else $error("address moved while selected");
    no_fight_a: assert property (!output_drive_n |-> !data_bus_oe)
        else $error("host drives during read");
    pulse_width_a: assert property ($fell(write_strobe_n) |-> (!chip_select_n && lanes_on)[*2])
        else $error("write pulse too short");
    sel_together_a: assert property ($fell(write_strobe_n) |-> $fell(chip_select_n))
        else $error("select not with strobe");
    chip_hold_a: assert property ($rose(write_strobe_n) |-> !$past(chip_select_n, 2))
        else $error("chip select short in write");
    data_setup_a: assert property ($rose(write_strobe_n) |-> $past(data_bus_oe))
        else $error("no write data before end");
    retain_off_a: assert property (retain_ok |-> chip_select_n && !req_ready)
        else $error("chip selected while parked");
    read_answer_a: assert property (req_valid && req_ready && !req_write |-> ##5 rsp_valid)
        else $error("read answer late");
    cover property ($rose(write_strobe_n));
    cover property (rsp_valid);
    cover property ($rose(retain_ok));
endmodule

bind sram_host sram_host_monitor mon_u (.*);

// ---- tb/sram_model.sv ----
// behavioural model of the asynchronous memory on the host's pins
`timescale 1ns/1ps
module sram_model #(
    parameter ACCESS_NS = 45
) (
    // host pins
    input  wire [17:0] word_address,
    input  wire        chip_select_n,
    input  wire        write_strobe_n,
    input  wire        output_drive_n,
    input  wire        low_lane_select_n,
    input  wire        high_lane_select_n,
    input  wire [15:0] data_bus_out,
    input  wire        data_bus_oe,
    // resolved bus level
    output wire [15:0] data_bus_in
);
    // ==========
    // storage and drivers
    reg  [15:0] cells [0:262143];
    reg  [15:0] noise = 16'h5A5A;
    wire        rd_en = !chip_select_n && !output_drive_n && write_strobe_n;
    wire [15:0] mask = rd_en ? {{8{!high_lane_select_n}}, {8{!low_lane_select_n}}} : 16'h0000;
    // data lags a full access time so slow answers are exercised
    wire [15:0] #(ACCESS_NS) late = cells[word_address];
    // a released bus never keeps its last value
    always #10 noise = {noise[14:0], noise[15] ^ noise[13]};
    assign data_bus_in = data_bus_oe ? data_bus_out : (late & mask) | (noise & ~mask);
    always @* begin
        if (!chip_select_n && !write_strobe_n) begin
            if (!low_lane_select_n)
                cells[word_address][7:0] = data_bus_in[7:0];
            if (!high_lane_select_n)
                cells[word_address][15:8] = data_bus_in[15:8];
        end
    end
endmodule

// ---- tb/sram_host_bench.sv ----
// self-checking bench for the sram host controller
`timescale 1ns/1ps
module sram_host_bench;
    reg         core_clk, rst, req_valid, req_write, retain_req;
    reg  [17:0] req_addr;
    reg  [15:0] req_wdata;
    reg  [1:0]  req_lanes;
    wire        req_ready, rsp_valid, retain_ok, chip_select_n, write_strobe_n, output_drive_n;
    wire        low_lane_select_n, high_lane_select_n, data_bus_oe;
    wire [17:0] word_address;
    wire [15:0] rsp_rdata, data_bus_in, data_bus_out;
    reg  [15:0] shadow [0:7];
    reg  [17:0] addr_tab [0:7];
    reg  [15:0] exp_q [$];
    reg  [31:0] seed;
    integer     fails, samples_checked, cycles, i;

    sram_host dut_u (.*);
    sram_model mem_u (.*);

    // ==========
    // helpers
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task check(input [15:0] seen, input [15:0] expd, input [8*10:1] what);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== expd) begin
                fails = fails + 1;
                $display("wrong value %0s expected %h seen %h", what, expd, seen);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // an empty lane mask means both bytes
    task req(input w, input [2:0] k, input [15:0] d, input [1:0] ln);
        reg [15:0] m;
        begin
            m = {{8{ln[1] | ~|ln}}, {8{ln[0] | ~|ln}}};
            @(negedge core_clk);
            req_valid = 1'b1;
            req_write = w;
            req_addr = addr_tab[k];
            req_wdata = d;
            req_lanes = ln;
            while (req_ready !== 1'b1) @(negedge core_clk);
            if (w)
                shadow[k] = (shadow[k] & ~m) | (d & m);
            else
                exp_q.push_back(shadow[k] & m);
            @(negedge core_clk);
            req_valid = 1'b0;
        end
    endtask

    // ==========
    // clock, watchers and sequence
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(negedge core_clk)
        if (rsp_valid === 1'b1)
            check(rsp_rdata, exp_q.pop_front(), "read data");
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            report_and_stop;
        end
    end
    initial begin
        {rst, req_valid, req_write, retain_req, req_addr, req_wdata, req_lanes} = 0;
        rst = 1'b1;
        {fails, samples_checked, cycles} = 0;
        seed = 32'hEA05;
        repeat (20) @(negedge core_clk);
        check({10'h000, chip_select_n, write_strobe_n, output_drive_n, low_lane_select_n,
               high_lane_select_n, data_bus_oe}, 16'h003E, "reset pins");
        rst = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            addr_tab[i] = {seed[17:3], i[2:0]};
        end
        addr_tab[0] = 18'h00000;
        addr_tab[7] = 18'h3FFFF;
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            req(1'b1, i[2:0], seed[15:0], 2'b00);
        end
        for (i = 0; i < 8; i = i + 1) req(1'b0, i[2:0], 16'h0000, 2'b11);
        $display("test full words done");
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            req(1'b1, i[2:0], seed[31:16], i[1:0]);
            req(1'b0, i[2:0], 16'h0000, ~i[1:0]);
        end
        $display("test byte lanes done");
        retain_req = 1'b1;
        repeat (30) if (retain_ok !== 1'b1) @(negedge core_clk);
        check({14'h0000, retain_ok, chip_select_n}, 16'h0003, "parked");
        retain_req = 1'b0;
        req(1'b0, 3'd7, 16'h0000, 2'b00);
        while (exp_q.size() != 0) @(negedge core_clk);
        $display("test retention done");
        report_and_stop;
    end
endmodule
